// ==== rtl/sfw_flash_seq.sv ====
// serial flash command sequencer: write latch, status registers and the read family
// link logic runs on sck; status state runs on clk_sys; array is read combinationally
module sfw_flash_seq #(
    parameter int STATUS_WRITE_CYCLES = sfw_pkg::STATUS_WRITE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] lane_in,
    output logic [3:0] lane_out,
    output logic [3:0] lane_oe,
    output logic [23:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic array_busy,
    input wire logic array_done,
    input wire logic suspend_flag,
    input wire logic quad_command_mode,
    output logic write_latch_flag,
    output logic busy_flag,
    output logic quad_lane_enable,
    output logic status_protect_low,
    output logic status_protect_high,
    output logic volatile_write_enable
);
    // ---------------- system domain ----------------
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic cs_rise;
    logic wel_reg;
    logic vol_reg;
    logic qe_reg;
    logic status_protect_low_reg;
    logic status_protect_high_reg;
    logic rst_arm_reg;
    logic [1:0] param_reg;
    logic [15:0] wtimer_reg;
    logic wbusy_reg;
    logic busy;
    logic [7:0] sr1;
    logic [7:0] sr2;
    logic [7:0] snap_sr1_reg;
    logic [7:0] snap_sr2_reg;
    logic snap_qpi_reg;
    logic snap_busy_reg;
    logic snap_qe_reg;
    logic [3:0] snap_dummy_reg;
    logic [3:0] dummy_sel;
    // frame results held by the link once sck stops
    logic [7:0] op_reg;
    logic [5:0] cnt_reg;
    logic [15:0] in_sr_reg;
    // decoded frame, valid on cs_rise
    logic len8;
    logic len16;
    logic len24;
    logic write_ok;
    logic wrsr_go;
    logic [7:0] wr_byte1;
    logic [7:0] wr_byte2;

    // chip select crosses as a level; frame end is its synchronised rising edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
        end else begin
            cs_s1_reg <= cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
        end
    end

    assign cs_rise = cs_s2_reg & ~cs_s3_reg;
    assign busy = wbusy_reg | array_busy;

    // whole-byte frame lengths; anything else terminates a write-type command
    assign len8 = (cnt_reg == sfw_pkg::BITS_OPCODE);
    assign len16 = (cnt_reg == sfw_pkg::BITS_ONE_DATA);
    assign len24 = (cnt_reg == sfw_pkg::BITS_TWO_DATA);
    assign write_ok = wel_reg | vol_reg;
    assign wrsr_go = cs_rise & ~busy & write_ok
        & (((op_reg == sfw_pkg::OP_WRSR1) & (len16 | len24))
        | ((op_reg == sfw_pkg::OP_WRSR2) & len16));
    assign wr_byte1 = len24 ? in_sr_reg[15:8] : in_sr_reg[7:0];
    assign wr_byte2 = in_sr_reg[7:0];

    // write latch: set wins over every clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wel_reg <= sfw_pkg::RST_WEL;
        end else if (cs_rise & ~busy & len8 & (op_reg == sfw_pkg::OP_WREN)) begin
            wel_reg <= 1'b1;
        end else if (cs_rise & ~busy & len8 & (op_reg == sfw_pkg::OP_WRDI)) begin
            wel_reg <= 1'b0;
        end else if (wrsr_go & ~vol_reg) begin
            wel_reg <= 1'b0;
        end else if (array_done) begin
            wel_reg <= 1'b0;
        end
    end

    // volatile write enable leaves the latch alone and is spent by the next status write
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            vol_reg <= 1'b0;
        end else if (cs_rise & ~busy & len8 & (op_reg == sfw_pkg::OP_WREN_VOL)) begin
            vol_reg <= 1'b1;
        end else if (wrsr_go) begin
            vol_reg <= 1'b0;
        end
    end

    // writable status bits; all other positions are read-only
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            qe_reg <= sfw_pkg::RST_QE;
            status_protect_low_reg <= sfw_pkg::RST_SRP;
            status_protect_high_reg <= sfw_pkg::RST_SRP;
        end else if (wrsr_go) begin
            if (op_reg == sfw_pkg::OP_WRSR2) begin
                qe_reg <= wr_byte1[sfw_pkg::SR2_QE];
                status_protect_high_reg <= wr_byte1[sfw_pkg::SR2_STATUS_PROTECT_HIGH];
            end else begin
                status_protect_low_reg <= wr_byte1[sfw_pkg::SR1_STATUS_PROTECT_LOW];
                qe_reg <= len24 & wr_byte2[sfw_pkg::SR2_QE];
                status_protect_high_reg <= len24 & wr_byte2[sfw_pkg::SR2_STATUS_PROTECT_HIGH];
            end
        end
    end

    // self-timed status write cycle; a volatile write needs no cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wbusy_reg <= 1'b0;
            wtimer_reg <= 16'h0000;
        end else if (wrsr_go & ~vol_reg) begin
            wbusy_reg <= 1'b1;
            wtimer_reg <= 16'(STATUS_WRITE_CYCLES - 1);
        end else if (wbusy_reg) begin
            if (wtimer_reg == 16'h0000) begin
                wbusy_reg <= 1'b0;
            end else begin
                wtimer_reg <= wtimer_reg - 16'h0001;
            end
        end
    end

    // read parameters and the two-step reset instruction
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            param_reg <= sfw_pkg::PARAM_DUMMY_RESET;
            rst_arm_reg <= 1'b0;
        end else if (cs_rise & ~busy) begin
            rst_arm_reg <= len8 & (op_reg == sfw_pkg::OP_RST_EN);
            if (len8 & rst_arm_reg & (op_reg == sfw_pkg::OP_RST)) begin
                param_reg <= sfw_pkg::PARAM_DUMMY_RESET;
            end else if (len16 & (op_reg == sfw_pkg::OP_SET_PARAM)) begin
                param_reg <= in_sr_reg[sfw_pkg::PARAM_DUMMY_LSB +: 2];
            end
        end
    end

    always_comb begin
        case (param_reg)
            2'h0: dummy_sel = sfw_pkg::DUMMY_4;
            2'h1: dummy_sel = sfw_pkg::DUMMY_6;
            default: dummy_sel = sfw_pkg::DUMMY_8;
        endcase
    end

    always_comb begin
        sr1 = 8'h00;
        sr1[sfw_pkg::SR1_BUSY] = busy;
        sr1[sfw_pkg::SR1_WEL] = wel_reg;
        sr1[sfw_pkg::SR1_STATUS_PROTECT_LOW] = status_protect_low_reg;
        sr2 = 8'h00;
        sr2[sfw_pkg::SR2_STATUS_PROTECT_HIGH] = status_protect_high_reg;
        sr2[sfw_pkg::SR2_QE] = qe_reg;
        sr2[sfw_pkg::SR2_SUS] = suspend_flag;
    end

    // snapshot follows system state while deselected and freezes for the frame
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            snap_sr1_reg <= 8'h00;
            snap_sr2_reg <= 8'h00;
            snap_qpi_reg <= 1'b0;
            snap_busy_reg <= 1'b0;
            snap_qe_reg <= 1'b0;
            snap_dummy_reg <= sfw_pkg::DUMMY_4;
        end else if (cs_s2_reg) begin
            snap_sr1_reg <= sr1;
            snap_sr2_reg <= sr2;
            snap_qpi_reg <= quad_command_mode;
            snap_busy_reg <= busy;
            snap_qe_reg <= qe_reg;
            snap_dummy_reg <= dummy_sel;
        end
    end

    assign write_latch_flag = wel_reg;
    assign busy_flag = busy;
    assign quad_lane_enable = qe_reg;
    assign status_protect_low = status_protect_low_reg;
    assign status_protect_high = status_protect_high_reg;
    assign volatile_write_enable = vol_reg;

    // ---------------- link domain (sck) ----------------
    sfw_pkg::sfw_link_state_t ls_reg;
    sfw_pkg::sfw_link_state_t ls_next;
    logic started_reg;
    logic first;
    logic [5:0] cnt_next;
    logic [15:0] in_sr_next;
    logic [23:0] addr_reg;
    logic [3:0] dcnt_reg;
    logic [3:0] dummy_reg;
    logic [2:0] idx_reg;
    logic [2:0] idx_last;
    sfw_pkg::sfw_width_t ow_reg;
    logic stat_sel_reg;
    logic [7:0] out_byte;
    logic [7:0] out_shift;
    logic [3:0] oe_mask;
    logic [3:0] lane_out_reg;
    logic [3:0] lane_oe_reg;

    // cleared while deselected so the first edge of each frame restarts decoding
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    assign first = ~started_reg;

    always_comb begin
        if (snap_qpi_reg) begin
            in_sr_next = {in_sr_reg[11:0], lane_in};
            cnt_next = (first ? 6'h00 : cnt_reg) + 6'h04;
        end else begin
            in_sr_next = {in_sr_reg[14:0], lane_in[0]};
            cnt_next = (first ? 6'h00 : cnt_reg) + 6'h01;
        end
        if (~first & (cnt_reg[5:3] == 3'h7)) begin
            cnt_next = cnt_reg;
        end
    end

    // input shifting and bit count; left frozen at frame end for the system side
    always_ff @(posedge sck) begin
        in_sr_reg <= in_sr_next;
        cnt_reg <= cnt_next;
        if ((first | (ls_reg == sfw_pkg::SFW_LS_CMD)) & (cnt_next == sfw_pkg::BITS_OPCODE)) begin
            op_reg <= in_sr_next[7:0];
        end
    end

    always_comb begin
        ls_next = first ? sfw_pkg::SFW_LS_CMD : ls_reg;
        case (ls_next)
            sfw_pkg::SFW_LS_CMD: begin
                if (cnt_next == sfw_pkg::BITS_OPCODE) begin
                    case (in_sr_next[7:0])
                        sfw_pkg::OP_RDSR1, sfw_pkg::OP_RDSR2: ls_next = sfw_pkg::SFW_LS_STAT;
                        sfw_pkg::OP_READ, sfw_pkg::OP_FAST: begin
                            ls_next = snap_busy_reg ? sfw_pkg::SFW_LS_SKIP : sfw_pkg::SFW_LS_ADDR;
                        end
                        sfw_pkg::OP_DUAL: begin
                            ls_next = (snap_busy_reg | snap_qpi_reg) ? sfw_pkg::SFW_LS_SKIP : sfw_pkg::SFW_LS_ADDR;
                        end
                        sfw_pkg::OP_QUAD: begin
                            ls_next = (snap_busy_reg | snap_qpi_reg | ~snap_qe_reg) ?
                                sfw_pkg::SFW_LS_SKIP : sfw_pkg::SFW_LS_ADDR;
                        end
                        default: ls_next = sfw_pkg::SFW_LS_SKIP;
                    endcase
                end
            end
            sfw_pkg::SFW_LS_ADDR: begin
                if (cnt_next == sfw_pkg::BITS_ADDR_END) begin
                    ls_next = (dummy_reg == 4'h0) ? sfw_pkg::SFW_LS_DATA : sfw_pkg::SFW_LS_DUMMY;
                end
            end
            sfw_pkg::SFW_LS_DUMMY: begin
                if (dcnt_reg + 4'h1 == dummy_reg) begin
                    ls_next = sfw_pkg::SFW_LS_DATA;
                end
            end
            sfw_pkg::SFW_LS_DATA: ls_next = sfw_pkg::SFW_LS_DATA;
            sfw_pkg::SFW_LS_STAT: ls_next = sfw_pkg::SFW_LS_STAT;
            sfw_pkg::SFW_LS_SKIP: ls_next = sfw_pkg::SFW_LS_SKIP;
            default: ls_next = sfw_pkg::SFW_LS_SKIP;
        endcase
    end

    always_ff @(posedge sck) begin
        ls_reg <= ls_next;
    end

    // read mode chosen from the opcode: lane width and dummy clocks
    always_ff @(posedge sck) begin
        if ((first | (ls_reg == sfw_pkg::SFW_LS_CMD)) & (cnt_next == sfw_pkg::BITS_OPCODE)) begin
            stat_sel_reg <= (in_sr_next[7:0] == sfw_pkg::OP_RDSR2);
            ow_reg <= snap_qpi_reg ? sfw_pkg::SFW_W4 : sfw_pkg::SFW_W1;
            dummy_reg <= 4'h0;
            case (in_sr_next[7:0])
                sfw_pkg::OP_FAST: dummy_reg <= snap_qpi_reg ? snap_dummy_reg : sfw_pkg::DUMMY_8;
                sfw_pkg::OP_DUAL: begin
                    ow_reg <= sfw_pkg::SFW_W2;
                    dummy_reg <= sfw_pkg::DUMMY_8;
                end
                sfw_pkg::OP_QUAD: begin
                    ow_reg <= sfw_pkg::SFW_W4;
                    dummy_reg <= sfw_pkg::DUMMY_8;
                end
                default: dummy_reg <= 4'h0;
            endcase
        end
    end

    // address capture, dummy count and output group index
    always_ff @(posedge sck) begin
        if (ls_next == sfw_pkg::SFW_LS_ADDR || (ls_reg == sfw_pkg::SFW_LS_ADDR && ~first)) begin
            if (ls_reg == sfw_pkg::SFW_LS_ADDR && ~first) begin
                addr_reg <= snap_qpi_reg ? {addr_reg[19:0], lane_in} : {addr_reg[22:0], lane_in[0]};
            end
        end
        if (ls_reg == sfw_pkg::SFW_LS_DATA && ~first && idx_reg == idx_last) begin
            addr_reg <= addr_reg + 24'h000001;
        end
        dcnt_reg <= (ls_reg == sfw_pkg::SFW_LS_DUMMY && ~first) ? dcnt_reg + 4'h1 : 4'h0;
        if (ls_next != ls_reg || first) begin
            idx_reg <= 3'h0;
        end else if (ls_reg == sfw_pkg::SFW_LS_DATA || ls_reg == sfw_pkg::SFW_LS_STAT) begin
            idx_reg <= (idx_reg == idx_last) ? 3'h0 : idx_reg + 3'h1;
        end
    end

    assign mem_addr = addr_reg;

    always_comb begin
        case (ow_reg)
            sfw_pkg::SFW_W2: begin
                idx_last = 3'h3;
                oe_mask = 4'h3;
                out_shift = out_byte << {idx_reg[1:0], 1'b0};
            end
            sfw_pkg::SFW_W4: begin
                idx_last = 3'h1;
                oe_mask = 4'hf;
                out_shift = out_byte << {idx_reg[0], 2'h0};
            end
            default: begin
                idx_last = 3'h7;
                oe_mask = 4'h2;
                out_shift = out_byte << idx_reg;
            end
        endcase
    end

    assign out_byte = (ls_reg == sfw_pkg::SFW_LS_STAT) ?
        (stat_sel_reg ? snap_sr2_reg : snap_sr1_reg) : mem_rdata;

    // outputs change on falling edges, released the moment chip select rises
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            lane_out_reg <= 4'h0;
            lane_oe_reg <= 4'h0;
        end else if (started_reg && (ls_reg == sfw_pkg::SFW_LS_DATA || ls_reg == sfw_pkg::SFW_LS_STAT)) begin
            lane_oe_reg <= oe_mask;
            case (ow_reg)
                sfw_pkg::SFW_W2: lane_out_reg <= {2'h0, out_shift[7:6]};
                sfw_pkg::SFW_W4: lane_out_reg <= out_shift[7:4];
                default: lane_out_reg <= {2'h0, out_shift[7], 1'b0};
            endcase
        end else begin
            lane_out_reg <= 4'h0;
            lane_oe_reg <= 4'h0;
        end
    end

    assign lane_out = lane_out_reg;
    assign lane_oe = lane_oe_reg;
endmodule : sfw_flash_seq

// ==== rtl/sfw_pkg.sv ====
// constants for the serial flash command sequencer: opcodes, status layout, timing
// assumes a 40 MHz system clock and a host that drives chip select and the serial clock
//
// Functional notes
// - Instruction starts on chip select fall; opcode first, MSB first, on rising edges.
// - Write-type instructions not ending on a whole byte do nothing; reads end anywhere.
// - Write enable opcode then chip select rise sets the write latch flag.
// - Volatile write enable routes next status write to volatile copies; latch untouched.
// - Write disable opcode then chip select rise clears the write latch flag.
// - Write latch flag clears at power-up and after program, erase, status writes.
// - Status reads are accepted any time, even while busy.
// - Status read shifts the register out MSB first on falling edges, repeating.
// - Status write changes only protect bits and the quad lane enable.
// - Status write must end after data bit eight or sixteen, else discarded.
// - Status write ending after one byte clears quad enable and high protect.
// - Valid status write runs a timed cycle with busy high throughout.
// - Busy rising for a status write clears the write latch flag.
// - Register-2 write takes one byte, updates quad enable and high protect.
// - Normal read takes 24-bit address, then streams data MSB first on falling edges.
// - Read address increments after each byte; stream continues until chip select rises.
// - Normal read while busy is ignored and disturbs nothing.
// - Fast read: address on rising edges, dummy clocks, then data on falling edges.
// - Quad command mode fast read dummy count is 4, 6 or 8 from parameter bits.
// - Quad mode dummy count defaults to 4 at power-up and reset instruction.
// - Dual output read: eight dummy clocks then two bits per clock on lanes 0,1.
// - Quad output read only with quad enable; eight dummies, four bits per clock.
package sfw_pkg;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WREN_VOL = 8'h50;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_WRSR1 = 8'h01;
    localparam logic [7:0] OP_WRSR2 = 8'h31;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0b;
    localparam logic [7:0] OP_DUAL = 8'h3b;
    localparam logic [7:0] OP_QUAD = 8'h6b;
    localparam logic [7:0] OP_SET_PARAM = 8'hc0;
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    // status register-1 bit positions
    localparam int SR1_BUSY = 0;
    localparam int SR1_WEL = 1;
    localparam int SR1_STATUS_PROTECT_LOW = 7;
    // status register-2 bit positions, counted within the second byte
    localparam int SR2_STATUS_PROTECT_HIGH = 0;
    localparam int SR2_QE = 1;
    localparam int SR2_SUS = 7;
    // read parameter field
    localparam int PARAM_DUMMY_LSB = 4;
    localparam logic [1:0] PARAM_DUMMY_RESET = 2'h0;
    localparam logic [3:0] DUMMY_4 = 4'h4;
    localparam logic [3:0] DUMMY_6 = 4'h6;
    localparam logic [3:0] DUMMY_8 = 4'h8;
    // frame bit counts
    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_ONE_DATA = 6'h10;
    localparam logic [5:0] BITS_TWO_DATA = 6'h18;
    localparam logic [5:0] BITS_ADDR_END = 6'h20;
    // timing
    localparam int CLK_SYS_MHZ = 40;
    localparam int STATUS_WRITE_TIME_NS = 10000;
    localparam int STATUS_WRITE_CYCLES = (STATUS_WRITE_TIME_NS * CLK_SYS_MHZ + 999) / 1000;
    // reset values
    localparam logic RST_WEL = 1'b0;
    localparam logic RST_QE = 1'b0;
    localparam logic RST_SRP = 1'b0;

    typedef enum logic [5:0] {
        SFW_LS_CMD = 6'h01,
        SFW_LS_ADDR = 6'h02,
        SFW_LS_DUMMY = 6'h04,
        SFW_LS_DATA = 6'h08,
        SFW_LS_STAT = 6'h10,
        SFW_LS_SKIP = 6'h20
    } sfw_link_state_t;

    typedef enum logic [1:0] {
        SFW_W1 = 2'h0,
        SFW_W2 = 2'h1,
        SFW_W4 = 2'h2
    } sfw_width_t;
endpackage : sfw_pkg

// ==== tb/sfw_flash_seq_sva.sv ====
// assertions on the flash sequencer ports
// assumes a bind to sfw_flash_seq with its busy length parameter handed on
module sfw_flash_seq_sva #(
    parameter int STATUS_WRITE_CYCLES = 8
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] lane_oe,
    input wire logic array_busy,
    input wire logic array_done,
    input wire logic quad_command_mode,
    input wire logic write_latch_flag,
    input wire logic busy_flag,
    input wire logic quad_lane_enable
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] cnt_reg;
    // counts status-write busy cycles only
    always_ff @(posedge clk_sys) begin
        if (srst || !busy_flag || array_busy) cnt_reg <= 16'h0;
        else cnt_reg <= cnt_reg + 16'h1;
    end
    sequence s_swr_start;
        $rose(busy_flag) && !array_busy && !$past(array_busy);
    endsequence
    property p_wel_busy;
        @(posedge clk_sys) disable iff (srst) s_swr_start |-> !write_latch_flag;
    endproperty
    a_wel_busy: assert property (p_wel_busy) else $error("latch set at write start");
    property p_busy_len;
        @(posedge clk_sys) disable iff (srst) $fell(busy_flag) && cnt_reg > 16'h4 |-> cnt_reg == STATUS_WRITE_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
    property p_reset;
        @(posedge clk_sys) disable iff (srst) $fell(srst) |-> !write_latch_flag && !quad_lane_enable;
    endproperty
    a_reset: assert property (p_reset) else $error("flags set after reset");
    property p_done;
        @(posedge clk_sys) disable iff (srst) array_done && cs_n && $past(cs_n, 8) |=> !write_latch_flag;
    endproperty
    a_done: assert property (p_done) else $error("latch kept after array done");
    property p_wel_hold;
        @(posedge clk_sys) disable iff (srst)
            !cs_n && $past(!cs_n) && $past(!cs_n, 2) && !$past(array_done) |-> $stable(write_latch_flag);
    endproperty
    a_wel_hold: assert property (p_wel_hold) else $error("latch moved inside frame");
    property p_oe_idle;
        @(posedge clk_sys) disable iff (srst) cs_n |-> lane_oe == 4'h0;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("lane driven while deselected");
    property p_quad_oe;
        @(posedge sck) disable iff (cs_n) lane_oe[3] && !quad_command_mode |-> quad_lane_enable;
    endproperty
    a_quad_oe: assert property (p_quad_oe) else $error("quad lanes without enable");
    property p_oe_shape;
        @(posedge sck) disable iff (cs_n) lane_oe inside {4'h0, 4'h2, 4'h3, 4'hf};
    endproperty
    a_oe_shape: assert property (p_oe_shape) else $error("bad lane enable set");
    property p_busy_arr;
        @(posedge clk_sys) disable iff (srst) $rose(array_busy) |-> ##[0:2] busy_flag;
    endproperty
    a_busy_arr: assert property (p_busy_arr) else $error("busy misses array work");
endmodule : sfw_flash_seq_sva

// ==== tb/sfw_host.sv ====
// host controller model: frames on cs_n, link clock runs only inside frames
// assumes the device samples on sck rise and drives on sck fall
module sfw_host (
    output logic sck,
    output logic cs_n,
    output logic [3:0] lane_in,
    input wire logic [3:0] lane_out,
    input wire logic [3:0] lane_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] drv = 4'h0;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
    end
    // released host lanes toggle so a missing device driver shows
    assign lane_in = (lane_oe & lane_out) | (~lane_oe & drv);
    task automatic frame(input logic [63:0] wr, input int nw, input int skip, input int nc, input int w,
                         output logic [63:0] rd);
        int i;
        rd = 64'h0;
        cs_n = 1'b0;
        #100;
        for (i = 0; i < nw + skip + nc; i++) begin
            drv = (i < nw) ? {3'h0, wr[nw - 1 - i]} : ~drv;
            #15 sck = 1'b1;
            if (i >= nw + skip) rd = (w == 4) ? {rd[59:0], lane_in} : (w == 2) ? {rd[61:0], lane_in[1:0]} : {rd[62:0], lane_in[1]};
            #15 sck = 1'b0;
        end
        #20 cs_n = 1'b1;
        #300;
    endtask : frame
endmodule : sfw_host

// ==== tb/testbench.sv ====
// self-checking bench for the flash command sequencer
// assumes the array is a pure function of the address and quad command mode stays off
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NCYC = 40;
    logic clk_sys, srst, sck, cs_n, array_busy, array_done, suspend_flag;
    logic [3:0] lane_in, lane_out, lane_oe;
    logic [23:0] mem_addr, a;
    logic [7:0] mem_rdata, b1, b2;
    logic write_latch_flag, busy_flag, quad_lane_enable, status_protect_low, status_protect_high, volatile_write_enable;
    logic e_wel = 1'b0, e_qe = 1'b0, e_spl = 1'b0, e_sph = 1'b0;
    logic [63:0] rd;
    logic [7:0] ops [4] = '{sfw_pkg::OP_READ, sfw_pkg::OP_FAST, sfw_pkg::OP_DUAL, sfw_pkg::OP_QUAD};
    int skips [4] = '{0, 8, 8, 8};
    int ncs [4] = '{16, 16, 8, 4};
    int ws [4] = '{1, 1, 2, 4};
    int num_errors = 0, tests_run = 0, cyc = 0, k;
    integer seed = 32'hf6b9;
    function automatic logic [7:0] mf(input logic [23:0] x);
        return x[7:0] ^ x[23:16] ^ 8'h3c;
    endfunction : mf
    assign mem_rdata = mf(mem_addr);
    sfw_flash_seq #(.STATUS_WRITE_CYCLES(NCYC)) DUT (.clk_sys(clk_sys), .srst(srst), .sck(sck), .cs_n(cs_n),
        .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .array_busy(array_busy), .array_done(array_done), .suspend_flag(suspend_flag),
        .quad_command_mode(1'b0),
        .write_latch_flag(write_latch_flag), .busy_flag(busy_flag), .quad_lane_enable(quad_lane_enable),
        .status_protect_low(status_protect_low), .status_protect_high(status_protect_high),
        .volatile_write_enable(volatile_write_enable));
    sfw_host host (.sck(sck), .cs_n(cs_n), .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic final_report();
        if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    task automatic cmd(input logic [7:0] op);
        host.frame({56'h0, op}, 8, 0, 0, 1, rd);
    endtask : cmd
    task automatic chk_flags();
        `CHK({write_latch_flag, status_protect_low, quad_lane_enable, status_protect_high}, {e_wel, e_spl, e_qe, e_sph})
    endtask : chk_flags
    task automatic wait_idle();
        repeat (200) if (busy_flag) @(negedge clk_sys);
        `CHK(busy_flag, 1'b0)
    endtask : wait_idle
    initial begin
        srst = 1'b1;
        array_busy = 1'b0;
        array_done = 1'b0;
        suspend_flag = 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys) srst = 1'b0;
        repeat (5) @(negedge clk_sys);
        chk_flags();
        cmd(sfw_pkg::OP_WREN);
        e_wel = 1'b1;
        chk_flags();
        cmd(sfw_pkg::OP_WREN_VOL);
        `CHK({write_latch_flag, volatile_write_enable}, 2'h3)
        b1 = $random(seed);
        b2 = $random(seed);
        host.frame({40'h0, sfw_pkg::OP_WRSR1, b1, b2}, 24, 0, 0, 1, rd);
        {e_spl, e_qe, e_sph} = {b1[7], b2[1:0]};
        `CHK({busy_flag, volatile_write_enable}, 2'h0)
        chk_flags();
        cmd(sfw_pkg::OP_WRDI);
        e_wel = 1'b0;
        chk_flags();
        host.frame({48'h0, sfw_pkg::OP_WRSR2, ~b2}, 16, 0, 0, 1, rd);
        host.frame({55'h0, sfw_pkg::OP_WREN, 1'b0}, 9, 0, 0, 1, rd);
        chk_flags();
        cmd(sfw_pkg::OP_WREN);
        b1 = $random(seed);
        b2 = $random(seed);
        host.frame({40'h0, sfw_pkg::OP_WRSR1, b1, b2}, 24, 0, 0, 1, rd);
        {e_wel, e_spl, e_qe, e_sph} = {1'b0, b1[7], b2[1:0]};
        `CHK(busy_flag, 1'b1)
        chk_flags();
        host.frame({56'h0, sfw_pkg::OP_RDSR1}, 8, 0, 16, 1, rd);
        `CHK(rd[15:0], {2{e_spl, 5'h0, e_wel, 1'b1}})
        wait_idle();
        cmd(sfw_pkg::OP_WREN);
        e_wel = 1'b1;
        host.frame({44'h0, sfw_pkg::OP_WRSR1, b1, b2[7:4]}, 20, 0, 0, 1, rd);
        chk_flags();
        host.frame({48'h0, sfw_pkg::OP_WRSR2, 8'h03}, 16, 0, 0, 1, rd);
        {e_wel, e_qe, e_sph} = 3'h3;
        chk_flags();
        wait_idle();
        for (k = 0; k < 16; k++) begin
            a = $random(seed);
            @(negedge clk_sys) suspend_flag = a[0];
            host.frame({32'h0, ops[k % 4], a}, 32, skips[k % 4], ncs[k % 4], ws[k % 4], rd);
            `CHK(rd[15:0], {mf(a), mf(a + 24'h1)})
            host.frame({56'h0, sfw_pkg::OP_RDSR2}, 8, 0, 8, 1, rd);
            `CHK(rd[7:0], {a[0], 5'h0, e_qe, e_sph})
        end
        cmd(sfw_pkg::OP_WREN);
        b1 = $random(seed);
        host.frame({48'h0, sfw_pkg::OP_WRSR1, b1}, 16, 0, 0, 1, rd);
        {e_wel, e_spl, e_qe, e_sph} = {1'b0, b1[7], 2'h0};
        chk_flags();
        wait_idle();
        host.frame({32'h0, sfw_pkg::OP_QUAD, a}, 32, 8, 4, 4, rd);
        @(negedge clk_sys) array_busy = 1'b1;
        cmd(sfw_pkg::OP_WREN);
        host.frame({32'h0, sfw_pkg::OP_READ, a}, 32, 0, 16, 1, rd);
        chk_flags();
        @(negedge clk_sys) array_busy = 1'b0;
        wait_idle();
        cmd(sfw_pkg::OP_WREN);
        e_wel = 1'b1;
        chk_flags();
        @(negedge clk_sys) array_done = 1'b1;
        @(negedge clk_sys) array_done = 1'b0;
        e_wel = 1'b0;
        @(negedge clk_sys);
        chk_flags();
        final_report();
    end
endmodule : testbench
bind sfw_flash_seq sfw_flash_seq_sva #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) u_sva (.clk_sys(clk_sys), .srst(srst),
    .sck(sck), .cs_n(cs_n), .lane_oe(lane_oe), .array_busy(array_busy), .array_done(array_done),
    .quad_command_mode(quad_command_mode), .write_latch_flag(write_latch_flag), .busy_flag(busy_flag),
    .quad_lane_enable(quad_lane_enable));
